//--- bench/cclr_host.sv
`timescale 1ns/10ps
module cclr_host (
	input wire logic sys_clk,
	output logic cs_n,
	output logic control_clock,
	output logic ctl_data_in,
	input wire logic ctl_data_out,
	input wire logic ctl_data_oe
);
	// No pull on the data line, so a released line reads as the inverse
	wire logic line_seen = ctl_data_oe ? ctl_data_out : ~ctl_data_out;
	initial begin
		cs_n = 1'b1;
		control_clock = 1'b0;
		ctl_data_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Six cycles a level, above the two-cycle sync latency
	task automatic xfer(input logic [7:0] b, input int n, inout logic [7:0] r);
		for (int i = 7; i > 7 - n; i--) begin
			ctl_data_in = b[i];
			control_clock = 1'b1;
			tick(6);
			r[i] = line_seen;
			control_clock = 1'b0;
			tick(6);
		end
	endtask
	// Select held low across both bytes; n2 short of 8 aborts byte 2
	task automatic instr(input logic [7:0] b1, input logic [7:0] b2, input int n2,
		output logic [7:0] r);
		r = 8'h00;
		cs_n = 1'b0;
		tick(6);
		xfer(b1, 8, r);
		if (b1[1]) xfer(b2, n2, r);
		cs_n = 1'b1;
		// Released line must not keep the last bit
		ctl_data_in = ~ctl_data_in;
		tick(8);
	endtask
endmodule

//--- bench/test_cclr_regs.sv
`timescale 1ns/10ps
module test_cclr_regs import cclr_pkg::*; ();
	logic sys_clk = 1'b0, rstn = 1'b0, tx_frame_sync = 1'b0, cs_n, control_clock, ctl_data_in;
	logic ctl_data_out, ctl_data_oe, powered_off_state, tx_pcm_out_en, alaw_sel, alaw_invert;
	logic frame_timing_sel, digital_loop_active, converter_loop_active, tx_voice_in_from_rx;
	logic decoder_active, amp_enable;
	logic [1:0] clock_ratio;
	logic [5:0] latch_out_en;
	logic [7:0] ctl_m = 8'h89, ldr_m = 8'h00, r, d;
	logic pwr_m = 1'b1;
	int mismatches = 0, tests_run = 0, cycles = 0, seed = 82;
	always #2.5 sys_clk = ~sys_clk;
	cclr_regs cclr_regs_inst (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
		.control_clock(control_clock), .ctl_data_in(ctl_data_in),
		.tx_frame_sync(tx_frame_sync), .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe),
		.powered_off_state(powered_off_state), .tx_pcm_out_en(tx_pcm_out_en),
		.clock_ratio(clock_ratio), .alaw_sel(alaw_sel), .alaw_invert(alaw_invert),
		.frame_timing_sel(frame_timing_sel), .digital_loop_active(digital_loop_active),
		.converter_loop_active(converter_loop_active),
		.tx_voice_in_from_rx(tx_voice_in_from_rx), .decoder_active(decoder_active),
		.amp_enable(amp_enable), .latch_out_en(latch_out_en));
	cclr_host cclr_host_inst (.sys_clk(sys_clk), .cs_n(cs_n), .control_clock(control_clock),
		.ctl_data_in(ctl_data_in), .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe));
	function automatic logic [10:0] exp_ctl(input logic [7:0] c, input logic p);
		return {c[7:6], c[5], c[5] & ~c[4], c[3], c[2], ~c[2] & c[1], ~c[2] & c[1],
			~p, ~p | ~c[0], p};
	endfunction
	function automatic logic [5:0] exp_lat(input logic [7:0] l);
		for (int n = 0; n < 6; n++) exp_lat[n] = l[7 - n];
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_all();
		cmp({clock_ratio, alaw_sel, alaw_invert, frame_timing_sel, digital_loop_active,
			converter_loop_active, tx_voice_in_from_rx, decoder_active, amp_enable,
			powered_off_state}, exp_ctl(ctl_m, pwr_m));
		cmp(latch_out_en, exp_lat(ldr_m));
		cmp(ctl_data_oe, 1'b0);
	endtask
	task automatic op(input logic [3:0] a, input logic rd, input logic [7:0] v, input logic p);
		logic [7:0] want;
		cclr_host_inst.instr({p, a, rd, 2'b10}, v, 8, r);
		if (!rd && a == ADDR_CODEC_CONTROL) ctl_m = v;
		if (!rd && a == ADDR_LATCH_DIRECTION) ldr_m = v & 8'hfc;
		pwr_m = p;
		check_all();
		want = a == ADDR_CODEC_CONTROL ? ctl_m : a == ADDR_LATCH_DIRECTION ? ldr_m : 8'h00;
		if (rd) cmp(r, want);
	endtask
	task automatic fs_pulse(input logic exp);
		tx_frame_sync = 1'b1;
		cclr_host_inst.tick(4);
		tx_frame_sync = 1'b0;
		cclr_host_inst.tick(8);
		cmp(tx_pcm_out_en, exp);
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Whole run needs about 9700 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		cclr_host_inst.tick(6);
		check_all();
		cmp(tx_pcm_out_en, 1'b0);
		// Byte 2 cut short after three bits
		cclr_host_inst.instr({1'b0, ADDR_CODEC_CONTROL, 3'b010}, 8'h00, 3, r);
		check_all();
		d = 8'($random(seed));
		cclr_host_inst.instr({1'b0, d[6:2], 1'b0, d[0]}, 8'h00, 8, r);
		pwr_m = 1'b0;
		check_all();
		cmp(tx_pcm_out_en, 1'b0);
		fs_pulse(1'b0);
		fs_pulse(1'b1);
		d = 8'($random(seed));
		cclr_host_inst.instr({1'b1, d[6:2], 1'b0, d[0]}, 8'h00, 8, r);
		pwr_m = 1'b1;
		check_all();
		cmp(tx_pcm_out_en, 1'b0);
		// Program while down, spare latches as outputs, power last
		op(ADDR_LATCH_DIRECTION, 1'b0, 8'hfc, 1'b1);
		op(ADDR_LATCH_DIRECTION, 1'b1, 8'h00, 1'b1);
		// Hybrid balance cleared before any analog loop below
		op(4'h6, 1'b0, 8'h00, 1'b1);
		for (int k = 0; k < 8; k++) begin
			d = {k[1:0], k[2], k[0], 1'b1, k[1], k[2], k[0]};
			op(ADDR_CODEC_CONTROL, 1'b0, d, k[1]);
			op(ADDR_CODEC_CONTROL, 1'b1, 8'h00, k[1]);
		end
		op(4'h5, 1'b1, 8'h00, 1'b0);
		for (int k = 0; k < 24; k++) begin
			d = 8'($random(seed));
			r = 8'($random(seed));
			case ({$random(seed)} % 3)
				0: op(ADDR_CODEC_CONTROL, r[0], d, r[1]);
				1: op(ADDR_LATCH_DIRECTION, r[0], d, r[1]);
				default: op(4'h5, r[0], d, r[1]);
			endcase
		end
		// Second reset in mid-run must restore every default
		rstn = 1'b0;
		cclr_host_inst.tick(4);
		rstn = 1'b1;
		cclr_host_inst.tick(6);
		ctl_m = CODEC_CONTROL_RESET;
		ldr_m = LATCH_DIRECTION_RESET;
		pwr_m = POWER_RESET;
		check_all();
		cmp(tx_pcm_out_en, 1'b0);
		op(ADDR_CODEC_CONTROL, 1'b1, 8'h00, 1'b1);
		print_verdict();
	end
endmodule

//--- src/cclr_pkg.sv
package cclr_pkg;
	// Instruction byte 1 field positions
	localparam int unsigned B1_POWER_BIT = 7;
	localparam int unsigned B1_ADDR_MSB = 6;
	localparam int unsigned B1_ADDR_LSB = 3;
	localparam int unsigned B1_READ_BIT = 2;
	localparam int unsigned B1_LEN_BIT = 1;
	// Register addresses of the two registers held here
	localparam logic [3:0] ADDR_CODEC_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_LATCH_DIRECTION = 4'h2;
	// Control register field positions
	localparam int unsigned CC_CLK_HI = 7;
	localparam int unsigned CC_CLK_LO = 6;
	localparam int unsigned CC_LAW = 5;
	localparam int unsigned CC_INV_OFF = 4;
	localparam int unsigned CC_TIMING = 3;
	localparam int unsigned CC_DLOOP = 2;
	localparam int unsigned CC_ALOOP = 1;
	localparam int unsigned CC_AMP = 0;
	// Latch direction field: latch 0 at bit 7 down to latch 5 at bit 2
	localparam int unsigned LD_TOP = 7;
	localparam int unsigned LATCH_COUNT = 6;
	localparam logic [7:0] LD_USED_MASK = 8'hfc;
	// Values after reset
	localparam logic [7:0] CODEC_CONTROL_RESET = 8'h89;
	localparam logic [7:0] LATCH_DIRECTION_RESET = 8'h00;
	localparam logic POWER_RESET = 1'b1;
	// Counts
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] FS_RELEASE_COUNT = 2'h2;
	typedef enum logic [2:0] {
		ST_BYTE1 = 3'b001,
		ST_WRITE2 = 3'b010,
		ST_READ2 = 3'b100
	} cclr_state_type;
endpackage

//--- src/cclr_regs.sv
// Summary of operation
// - Any accepted instruction powers up on bit 7 at 0, down at 1.
// - Power-up wakes circuits; PCM output stays off until second frame sync.
// - Register writes accepted in either power state, power bit applied together.
// - Control byte: clock hi, clock lo, law, inversion off, timing, loops, amp.
// - Clock select code picks the master clock divider.
// - Law bit 0 gives mu-law; 1 gives A-law, inversion bit chooses inversion.
// - Power-on control defaults: 2.048 MHz code, mu-law, non-delayed, no loop, amp off.
// - Digital loop bit wins; else analog loop bit; both 0 is normal.
// - Analog loop ties transmit input to receive output internally.
// - Digital loop sends receive PCM register on transmit output.
// - Decoder keeps driving receive output during digital loop.
// - Amp select 0 keeps amp on in power-down, 1 turns it off.
// - After power-on every latch is an input.
// - Latch direction bits 7..2 for latches 0..5, 1 is output.
// - Byte 1: power bit 7, address 6..3, read bit 2, length bit 1.
// - Second byte loads only after its eighth control clock.
`timescale 1ns/10ps
module cclr_regs import cclr_pkg::*; (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic control_clock,
	input wire logic ctl_data_in,
	input wire logic tx_frame_sync,
	output logic ctl_data_out,
	output logic ctl_data_oe,
	output logic powered_off_state,
	output logic tx_pcm_out_en,
	output logic [1:0] clock_ratio,
	output logic alaw_sel,
	output logic alaw_invert,
	output logic frame_timing_sel,
	output logic digital_loop_active,
	output logic converter_loop_active,
	output logic tx_voice_in_from_rx,
	output logic decoder_active,
	output logic amp_enable,
	output logic [LATCH_COUNT-1:0] latch_out_en
);
	logic [3:0] pins_s;
	logic cs_n_s, control_clock_s, din_s, fsx_s;
	logic control_clock_q_ff, fsx_q_ff;
	logic control_clock_fall, control_clock_rise, fs_rise;
	cclr_state_type state_ff, nxt_state;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [7:0] in_shift_ff, nxt_in_shift;
	logic [7:0] out_shift_ff, nxt_out_shift;
	logic [3:0] addr_ff, nxt_addr;
	logic hold_power_ff, nxt_hold_power;
	logic power_ff, nxt_power;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [7:0] ldr_ff, nxt_ldr;
	logic out_ff, nxt_out;
	logic oe_ff, nxt_oe;
	logic [7:0] byte_in;
	logic byte_done;
	logic [1:0] fs_cnt_ff, nxt_fs_cnt;
	logic release_ff, nxt_release;

	// Pins come from the host's domain
	cclr_sync #(.WIDTH(4)) cclr_sync_inst (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in({cs_n, control_clock, ctl_data_in, tx_frame_sync}),
		.sync_out(pins_s)
	);
	assign {cs_n_s, control_clock_s, din_s, fsx_s} = pins_s;
	assign control_clock_fall = control_clock_q_ff & ~control_clock_s;
	assign control_clock_rise = ~control_clock_q_ff & control_clock_s;
	assign fs_rise = ~fsx_q_ff & fsx_s;
	assign byte_in = {in_shift_ff[6:0], din_s};
	assign byte_done = ~cs_n_s & control_clock_fall & (cnt_ff == LAST_BIT);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_in_shift = in_shift_ff;
		nxt_out_shift = out_shift_ff;
		nxt_addr = addr_ff;
		nxt_hold_power = hold_power_ff;
		nxt_power = power_ff;
		nxt_ctrl = ctrl_ff;
		nxt_ldr = ldr_ff;
		nxt_out = out_ff;
		if (cs_n_s) begin
			// Early chip select release drops the partial instruction
			nxt_state = ST_BYTE1;
			nxt_cnt = '0;
		end else begin
			if (control_clock_rise && state_ff == ST_READ2) begin
				nxt_out = out_shift_ff[7];
				nxt_out_shift = {out_shift_ff[6:0], 1'b0};
			end
			if (control_clock_fall) begin
				nxt_in_shift = byte_in;
				nxt_cnt = cnt_ff + 3'h1;
			end
			if (byte_done) begin
				case (state_ff)
					ST_BYTE1: begin
						if (!byte_in[B1_LEN_BIT]) begin
							nxt_power = byte_in[B1_POWER_BIT];
						end else begin
							nxt_hold_power = byte_in[B1_POWER_BIT];
							nxt_addr = byte_in[B1_ADDR_MSB:B1_ADDR_LSB];
							if (byte_in[B1_READ_BIT]) begin
								nxt_state = ST_READ2;
								if (byte_in[B1_ADDR_MSB:B1_ADDR_LSB] == ADDR_CODEC_CONTROL) begin
									nxt_out_shift = ctrl_ff;
								end else if (byte_in[B1_ADDR_MSB:B1_ADDR_LSB] ==
									ADDR_LATCH_DIRECTION) begin
									nxt_out_shift = ldr_ff;
								end else begin
									// Registers kept elsewhere read as zero here
									nxt_out_shift = 8'h00;
								end
							end else begin
								nxt_state = ST_WRITE2;
							end
						end
					end
					ST_WRITE2: begin
						nxt_state = ST_BYTE1;
						nxt_power = hold_power_ff;
						if (addr_ff == ADDR_CODEC_CONTROL) begin
							nxt_ctrl = byte_in;
						end
						if (addr_ff == ADDR_LATCH_DIRECTION) begin
							nxt_ldr = byte_in & LD_USED_MASK;
						end
					end
					ST_READ2: begin
						nxt_state = ST_BYTE1;
						nxt_power = hold_power_ff;
					end
					default: begin
						nxt_state = ST_BYTE1;
					end
				endcase
			end
		end
		nxt_oe = ~cs_n_s & (nxt_state == ST_READ2);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_BYTE1;
			cnt_ff <= '0;
			in_shift_ff <= '0;
			out_shift_ff <= '0;
			addr_ff <= '0;
			hold_power_ff <= POWER_RESET;
			power_ff <= POWER_RESET;
			ctrl_ff <= CODEC_CONTROL_RESET;
			ldr_ff <= LATCH_DIRECTION_RESET;
			out_ff <= 1'b0;
			oe_ff <= 1'b0;
			control_clock_q_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			in_shift_ff <= nxt_in_shift;
			out_shift_ff <= nxt_out_shift;
			addr_ff <= nxt_addr;
			hold_power_ff <= nxt_hold_power;
			power_ff <= nxt_power;
			ctrl_ff <= nxt_ctrl;
			ldr_ff <= nxt_ldr;
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
			control_clock_q_ff <= control_clock_s;
		end
	end

	// Transmit output release counts frame syncs after power-up
	always_comb begin
		nxt_fs_cnt = fs_cnt_ff;
		nxt_release = release_ff;
		if (power_ff || nxt_power) begin
			nxt_fs_cnt = '0;
			nxt_release = 1'b0;
		end else if (fs_rise && !release_ff) begin
			nxt_fs_cnt = fs_cnt_ff + 2'h1;
			nxt_release = (fs_cnt_ff + 2'h1) == FS_RELEASE_COUNT;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fs_cnt_ff <= '0;
			release_ff <= 1'b0;
			fsx_q_ff <= 1'b0;
		end else begin
			fs_cnt_ff <= nxt_fs_cnt;
			release_ff <= nxt_release;
			fsx_q_ff <= fsx_s;
		end
	end

	assign ctl_data_out = out_ff;
	assign ctl_data_oe = oe_ff;
	assign powered_off_state = power_ff;
	assign tx_pcm_out_en = release_ff;
	assign clock_ratio = {ctrl_ff[CC_CLK_HI], ctrl_ff[CC_CLK_LO]};
	assign alaw_sel = ctrl_ff[CC_LAW];
	assign alaw_invert = ctrl_ff[CC_LAW] & ~ctrl_ff[CC_INV_OFF];
	assign frame_timing_sel = ctrl_ff[CC_TIMING];
	assign digital_loop_active = ctrl_ff[CC_DLOOP];
	assign converter_loop_active = ~ctrl_ff[CC_DLOOP] & ctrl_ff[CC_ALOOP];
	assign tx_voice_in_from_rx = converter_loop_active;
	// Decoder ignores loop mode; muting is the gain register's job
	assign decoder_active = ~power_ff;
	assign amp_enable = ~power_ff | ~ctrl_ff[CC_AMP];
	genvar gi;
	for (gi = 0; gi < LATCH_COUNT; gi++) begin : g_latch
		assign latch_out_en[gi] = ldr_ff[LD_TOP - gi];
	end

	property p_single_power;
		@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_BYTE1 && !byte_in[B1_LEN_BIT]
		|=> power_ff == $past(byte_in[B1_POWER_BIT]);
	endproperty
	a_single_power: assert property (p_single_power) else $error("single byte power");

	property p_ctrl_load;
		@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_WRITE2 && addr_ff == ADDR_CODEC_CONTROL
		|=> ctrl_ff == $past(byte_in) && power_ff == $past(hold_power_ff);
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control write lost");

	property p_ctrl_only_on_eighth;
		@(posedge sys_clk) disable iff (!rstn)
		!byte_done |=> $stable(ctrl_ff) && $stable(ldr_ff);
	endproperty
	a_ctrl_only_on_eighth: assert property (p_ctrl_only_on_eighth) else $error("early");

	property p_abort;
		@(posedge sys_clk) disable iff (!rstn)
		cs_n_s |=> state_ff == ST_BYTE1 && cnt_ff == 3'h0 && !ctl_data_oe;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not reset count");

	property p_hold_off;
		@(posedge sys_clk) disable iff (!rstn)
		$fell(power_ff) |-> !tx_pcm_out_en [*2];
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("pcm released early");

	property p_release_cause;
		@(posedge sys_clk) disable iff (!rstn)
		$rose(tx_pcm_out_en) |-> $past(fs_rise) && $past(fs_cnt_ff) == 2'h1 && !power_ff;
	endproperty
	a_release_cause: assert property (p_release_cause) else $error("bad release");

	property p_amp_sleep;
		@(posedge sys_clk) disable iff (!rstn)
		power_ff && ctrl_ff[CC_AMP] |-> !amp_enable;
	endproperty
	a_amp_sleep: assert property (p_amp_sleep) else $error("amp on in power-down");

	property p_ldr_low_zero;
		@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_WRITE2 && addr_ff == ADDR_LATCH_DIRECTION
		|=> ldr_ff[1:0] == 2'h0 && latch_out_en[0] == $past(byte_in[7]);
	endproperty
	a_ldr_low_zero: assert property (p_ldr_low_zero) else $error("latch dir write");

	property p_read_bit;
		@(posedge sys_clk) disable iff (!rstn)
		!cs_n_s && control_clock_rise && state_ff == ST_READ2 |=> ctl_data_out == $past(out_shift_ff[7]);
	endproperty
	a_read_bit: assert property (p_read_bit) else $error("read bit wrong");

	c_ctrl_write: cover property (@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_WRITE2 && addr_ff == ADDR_CODEC_CONTROL);
	c_read_back: cover property (@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_READ2);
	c_release: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(tx_pcm_out_en));
	c_single: cover property (@(posedge sys_clk) disable iff (!rstn)
		byte_done && state_ff == ST_BYTE1 && !byte_in[B1_LEN_BIT]);
endmodule

//--- src/cclr_sync.sv
`timescale 1ns/10ps
module cclr_sync import cclr_pkg::*; #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_out = stage2_ff;
endmodule
